// >>> hw/codec_cfg_pkg.sv
// codec_cfg_pkg: constants and types of the codec configuration logic
// assumes: shared by the port shifter, pin synchroniser and the top module
package codec_cfg_pkg;
    // address byte layout
    localparam int           ADDR_ID_HI   = 7;
    localparam int           ADDR_ID_LO   = 2;
    localparam int           ADDR_SET_HI  = 1;
    localparam int           ADDR_SET_LO  = 0;
    localparam logic [1:0]   SET_DATA     = 2'h0;
    localparam logic [1:0]   SET_STATUS   = 2'h2;
    // data byte layout
    localparam int           SEL_HI       = 7;
    localparam int           SEL_LO       = 6;
    localparam int           VAL_HI       = 5;
    localparam int           VAL_LO       = 0;
    localparam logic [1:0]   SEL_CFG      = 2'h0;
    localparam logic [1:0]   SEL_ATTEN    = 2'h0;
    localparam logic [1:0]   SEL_UNUSED   = 2'h1;
    localparam logic [1:0]   SEL_EMPH     = 2'h2;
    localparam logic [1:0]   SEL_POWER    = 2'h3;
    // field positions inside the 6-bit registers
    localparam int           CFG_RATIO_HI = 5;
    localparam int           CFG_RATIO_LO = 4;
    localparam int           CFG_FMT_HI   = 3;
    localparam int           CFG_FMT_LO   = 1;
    localparam int           CFG_DC       = 0;
    localparam int           EMPH_HI      = 4;
    localparam int           EMPH_LO      = 3;
    localparam int           MUTE_BIT     = 2;
    localparam int           PWR_ADC      = 1;
    localparam int           PWR_DAC      = 0;
    localparam logic [5:0]   REG_RESET    = 6'h00;
    // field encodings
    localparam logic [1:0]   RATIO_512    = 2'h0;
    localparam logic [1:0]   RATIO_384    = 2'h1;
    localparam logic [1:0]   RATIO_256    = 2'h2;
    localparam logic [2:0]   FMT_I2S      = 3'h0;
    localparam logic [2:0]   FMT_MSB      = 3'h4;
    localparam logic [2:0]   FMT_MSB_L16  = 3'h5;
    localparam logic [2:0]   FMT_MSB_L20  = 3'h7;
    localparam logic [1:0]   EMPH_OFF     = 2'h0;
    localparam logic [1:0]   EMPH_44K1    = 2'h2;
    localparam logic [5:0]   ATTEN_UNITY  = 6'h01;
    localparam logic [5:0]   ATTEN_FULL   = 6'h3f;
    localparam logic [2:0]   BIT_LAST     = 3'h7;
    localparam logic [2:0]   BIT_FIRST    = 3'h1;

    // three-level pin as seen through a pair of comparators
    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_MID  = 2'b01,
        LVL_HIGH = 2'b11
    } level_e;

    typedef enum logic [1:0] {
        MODE_SERIAL = 2'b00,
        MODE_TEST   = 2'b01,
        MODE_STATIC = 2'b11
    } mode_e;

    typedef struct packed {
        logic   mode_a;
        logic   mode_b;
        logic   fmt_a;
        logic   fmt_b;
        logic   ratio;
        level_e play;
        level_e adc;
    } pins_s;
endpackage

// >>> hw/port_link_if.sv
// port_link_if: byte handed from the port clock domain to the reference domain
// assumes: byte_val and is_data stay stable between two flips of byte_toggle
`timescale 1ns/1ps
`default_nettype none
interface port_link_if;
    logic [7:0] byte_val;
    logic       is_data;
    logic       byte_toggle;
    modport link (output byte_val, output is_data, output byte_toggle);
    modport core (input byte_val, input is_data, input byte_toggle);
endinterface
`default_nettype wire

// >>> hw/pin_sync.sv
// pin_sync: two-flop synchroniser for the static configuration pins
// assumes: pins are slow levels from outside the reference clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import codec_cfg_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    input  wire codec_cfg_pkg::pins_s pins_in,
    output var  codec_cfg_pkg::pins_s pins_out
);
    typedef struct packed {
        pins_s s1;
        pins_s s2;
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = pins_in;
        s_nxt.s2 = s_r.s1;
        if (rst_in) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        s_r <= s_nxt;
    end

    assign pins_out = s_r.s2;
endmodule // pin_sync
`default_nettype wire

// >>> hw/port_shifter.sv
// port_shifter: assembles bytes from the three-wire port on the port clock
// assumes: host sets data before each rising port clock edge, where it is sampled; rst_in is resynchronised here
`timescale 1ns/1ps
`default_nettype none
module port_shifter
    import codec_cfg_pkg::*;
(
    input  wire logic port_clock_line_in,
    input  wire logic rst_in,
    input  wire logic port_phase_line_in,
    input  wire logic port_data_line_in,
    port_link_if.link lnk
);
    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       last_phase;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic [7:0] byte_val;
        logic       is_data;
        logic       toggle;
    } shift_s;

    shift_s s_r;
    shift_s s_nxt;

    always_comb begin
        s_nxt            = s_r;
        s_nxt.rst_s1     = rst_in;
        s_nxt.rst_s2     = s_r.rst_s1;
        s_nxt.last_phase = port_phase_line_in;
        // data line is only ever sampled, never driven
        // new bits enter at the top so the first bit ends in bit 0
        s_nxt.shreg      = {port_data_line_in, s_r.shreg[7:1]};
        if (port_phase_line_in != s_r.last_phase) begin
            // a phase change restarts the byte
            s_nxt.shreg = {port_data_line_in, 7'h00};
            s_nxt.cnt   = BIT_FIRST;
        end else if (s_r.cnt == BIT_LAST) begin
            // eighth edge of the group completes a byte
            s_nxt.cnt      = 3'h0;
            s_nxt.byte_val = {port_data_line_in, s_r.shreg[7:1]};
            s_nxt.is_data  = port_phase_line_in;
            s_nxt.toggle   = ~s_r.toggle;
        end else begin
            s_nxt.cnt = s_r.cnt + 3'h1;
        end
        if (s_r.rst_s2) begin
            s_nxt        = '0;
            s_nxt.rst_s1 = rst_in;
            s_nxt.rst_s2 = s_r.rst_s1;
        end
    end

    always_ff @(posedge port_clock_line_in) begin
        s_r <= s_nxt;
    end

    assign lnk.byte_val    = s_r.byte_val;
    assign lnk.is_data     = s_r.is_data;
    assign lnk.byte_toggle = s_r.toggle;
endmodule // port_shifter
`default_nettype wire

// >>> hw/codec_config.sv
// codec_config: control port interpreter and static pin decoder of the codec
// assumes: host keeps port rate low enough for a byte to cross before the next one
`timescale 1ns/1ps
`default_nettype none
module codec_config
    import codec_cfg_pkg::*;
#(
    // device address; value is arbitrary
    parameter logic [5:0] DEVICE_ADDRESS = 6'h2a
)
(
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 port_clock_line_in,
    input  wire logic                 port_phase_line_in,
    input  wire logic                 port_data_line_in,
    input  wire logic                 mode_select_pin_a_in,
    input  wire logic                 mode_select_pin_b_in,
    input  wire logic                 format_pin_a_in,
    input  wire logic                 format_pin_b_in,
    input  wire logic                 clock_ratio_pin_in,
    input  wire logic [1:0]           playback_three_level_pin_in,
    input  wire logic [1:0]           adc_three_level_pin_in,
    output var  codec_cfg_pkg::mode_e control_mode_out,
    output var  logic                 port_selected_out,
    output var  logic [1:0]           clock_ratio_out,
    output var  logic [2:0]           serial_format_out,
    output var  logic                 offset_removal_enable_out,
    output var  logic [5:0]           attenuation_code_out,
    output var  logic [5:0]           attenuation_db_out,
    output var  logic                 full_attenuation_out,
    output var  logic [1:0]           emphasis_out,
    output var  logic                 playback_silence_out,
    output var  logic                 adc_power_enable_out,
    output var  logic                 dac_power_enable_out,
    output var  logic                 adc_gain_6db_out
);
    import codec_cfg_pkg::*;

    typedef struct packed {
        logic       tog1;
        logic       tog2;
        logic       tog3;
        mode_e      mode;
        logic       sel;
        logic [1:0] set;
        logic [5:0] cfg;
        logic [5:0] atten;
        logic [5:0] emph;
        logic [5:0] pwr;
        logic [1:0] ratio_o;
        logic [2:0] fmt_o;
        logic       dc_o;
        logic [5:0] code_o;
        logic [5:0] db_o;
        logic       full_o;
        logic [1:0] emph_o;
        logic       mute_o;
        logic       adc_o;
        logic       dac_o;
        logic       gain_o;
    } core_s;

    core_s      s_r;
    core_s      s_nxt;
    pins_s      pins_raw;
    pins_s      p;
    logic       new_byte;
    logic [1:0] top;
    logic [5:0] val;

    port_link_if lnk ();

    port_shifter u_shifter (
        .port_clock_line_in (port_clock_line_in),
        .rst_in             (rst_in),
        .port_phase_line_in (port_phase_line_in),
        .port_data_line_in  (port_data_line_in),
        .lnk                (lnk.link)
    );

    assign pins_raw = '{mode_a: mode_select_pin_a_in, mode_b: mode_select_pin_b_in,
                        fmt_a: format_pin_a_in, fmt_b: format_pin_b_in,
                        ratio: clock_ratio_pin_in,
                        play: level_e'(playback_three_level_pin_in),
                        adc: level_e'(adc_three_level_pin_in)};

    pin_sync u_pins (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pins_in    (pins_raw),
        .pins_out   (p)
    );

    function automatic mode_e mode_of(input logic a, input logic b);
        if (!a && !b) begin
            return MODE_SERIAL;
        end else if (a && b) begin
            return MODE_STATIC;
        end
        return MODE_TEST;
    endfunction

    function automatic logic [2:0] static_fmt(input logic a, input logic b);
        case ({a, b})
            2'b00:   return FMT_MSB;
            2'b01:   return FMT_I2S;
            2'b10:   return FMT_MSB_L20;
            default: return FMT_MSB_L16;
        endcase
    endfunction

    // toggle crossing: tog1 feeds only tog2, edge taken between tog2 and tog3
    assign new_byte = s_r.tog2 ^ s_r.tog3;
    assign top      = lnk.byte_val[SEL_HI:SEL_LO];
    assign val      = lnk.byte_val[VAL_HI:VAL_LO];

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tog1 = lnk.byte_toggle;
        s_nxt.tog2 = s_r.tog1;
        s_nxt.tog3 = s_r.tog2;
        s_nxt.mode = mode_of(p.mode_a, p.mode_b);
        if (s_r.mode == MODE_SERIAL && new_byte) begin
            if (!lnk.is_data) begin
                // address phase: match and pick the set
                s_nxt.sel = lnk.byte_val[ADDR_ID_HI:ADDR_ID_LO] == DEVICE_ADDRESS;
                s_nxt.set = lnk.byte_val[ADDR_SET_HI:ADDR_SET_LO];
            end else if (s_r.sel && s_r.set == SET_STATUS) begin
                // selection from the last address stays in force
                if (top == SEL_CFG) begin
                    s_nxt.cfg = val;
                end
            end else if (s_r.sel && s_r.set == SET_DATA) begin
                case (top)
                    SEL_ATTEN: s_nxt.atten = val;
                    SEL_EMPH:  s_nxt.emph  = val;
                    SEL_POWER: s_nxt.pwr   = val;
                    default:   s_nxt.atten = s_r.atten;
                endcase
            end
        end
        case (s_r.mode)
            MODE_SERIAL: begin
                s_nxt.ratio_o = s_r.cfg[CFG_RATIO_HI:CFG_RATIO_LO];
                s_nxt.fmt_o   = s_r.cfg[CFG_FMT_HI:CFG_FMT_LO];
                s_nxt.dc_o    = s_r.cfg[CFG_DC];
                s_nxt.code_o  = s_r.atten;
                // 1 dB per step above unity, top code is full cut
                s_nxt.db_o    = (s_r.atten <= ATTEN_UNITY) ? 6'h00 : s_r.atten - ATTEN_UNITY;
                s_nxt.full_o  = s_r.atten == ATTEN_FULL;
                s_nxt.emph_o  = s_r.emph[EMPH_HI:EMPH_LO];
                s_nxt.mute_o  = s_r.emph[MUTE_BIT];
                s_nxt.adc_o   = s_r.pwr[PWR_ADC];
                s_nxt.dac_o   = s_r.pwr[PWR_DAC];
                s_nxt.gain_o  = p.fmt_b;
            end
            MODE_STATIC: begin
                s_nxt.ratio_o = p.ratio ? RATIO_384 : RATIO_256;
                s_nxt.fmt_o   = static_fmt(p.fmt_a, p.fmt_b);
                s_nxt.dc_o    = 1'b0;
                s_nxt.code_o  = 6'h00;
                s_nxt.db_o    = 6'h00;
                s_nxt.full_o  = 1'b0;
                s_nxt.emph_o  = (p.play == LVL_MID) ? EMPH_44K1 : EMPH_OFF;
                s_nxt.mute_o  = p.play == LVL_HIGH;
                s_nxt.adc_o   = p.adc != LVL_LOW;
                s_nxt.dac_o   = 1'b1;
                s_nxt.gain_o  = p.adc == LVL_MID;
            end
            default: begin
                // test modes freeze the settings in force
                s_nxt.ratio_o = s_r.ratio_o;
            end
        endcase
        if (rst_in) begin
            // power-up default of every register is REG_RESET; host may rewrite any of them
            s_nxt       = '0;
            s_nxt.cfg   = REG_RESET;
            s_nxt.atten = REG_RESET;
            s_nxt.emph  = REG_RESET;
            s_nxt.pwr   = REG_RESET;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        s_r <= s_nxt;
    end

    assign control_mode_out          = s_r.mode;
    assign port_selected_out         = s_r.sel;
    assign clock_ratio_out           = s_r.ratio_o;
    assign serial_format_out         = s_r.fmt_o;
    assign offset_removal_enable_out = s_r.dc_o;
    assign attenuation_code_out      = s_r.code_o;
    assign attenuation_db_out        = s_r.db_o;
    assign full_attenuation_out      = s_r.full_o;
    assign emphasis_out              = s_r.emph_o;
    assign playback_silence_out      = s_r.mute_o;
    assign adc_power_enable_out      = s_r.adc_o;
    assign dac_power_enable_out      = s_r.dac_o;
    assign adc_gain_6db_out          = s_r.gain_o;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_static_play;
        s_r.mode == MODE_STATIC && p.play == LVL_HIGH |=> playback_silence_out && emphasis_out == EMPH_OFF;
    endproperty
    a_static_play: assert property (p_static_play) else $error("static high pin did not mute");

    property p_static_fmt;
        s_r.mode == MODE_STATIC && !p.fmt_a && p.fmt_b |=> serial_format_out == FMT_I2S;
    endproperty
    a_static_fmt: assert property (p_static_fmt) else $error("static format not I2S");

    property p_static_adc;
        s_r.mode == MODE_STATIC && p.adc == LVL_LOW |=> !adc_power_enable_out && !adc_gain_6db_out;
    endproperty
    a_static_adc: assert property (p_static_adc) else $error("ADC not powered down");

    property p_mismatch;
        s_r.mode == MODE_SERIAL && new_byte && !lnk.is_data
            && lnk.byte_val[ADDR_ID_HI:ADDR_ID_LO] != DEVICE_ADDRESS |=> !port_selected_out;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("foreign address kept selection");

    property p_volume;
        s_r.mode == MODE_SERIAL && new_byte && lnk.is_data && s_r.sel
            && s_r.set == SET_DATA && top == SEL_ATTEN |=> ##1 attenuation_code_out == $past(val, 2);
    endproperty
    a_volume: assert property (p_volume) else $error("volume byte not applied");

    property p_status;
        s_r.mode == MODE_SERIAL && new_byte && lnk.is_data && s_r.sel
            && s_r.set == SET_STATUS && top == SEL_CFG |=> s_r.cfg == $past(val);
    endproperty
    a_status: assert property (p_status) else $error("status byte not stored");

    property p_ignore;
        new_byte && lnk.is_data && (!s_r.sel || top == SEL_UNUSED && s_r.set == SET_DATA)
            |=> $stable(s_r.atten) && $stable(s_r.emph) && $stable(s_r.pwr) && $stable(s_r.cfg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored byte changed a register");

    property p_only_on_byte;
        !new_byte |=> $stable(s_r.atten) && $stable(s_r.cfg) && $stable(s_r.sel);
    endproperty
    a_only_on_byte: assert property (p_only_on_byte) else $error("register moved without a byte");

    property p_test_mode;
        p.mode_a != p.mode_b |=> control_mode_out == MODE_TEST;
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("mixed mode pins not test");

    property p_unity;
        s_r.mode == MODE_SERIAL && s_r.atten <= ATTEN_UNITY |=> attenuation_db_out == 6'h00;
    endproperty
    a_unity: assert property (p_unity) else $error("low volume codes not unity");

    property p_emph_byte;
        s_r.mode == MODE_SERIAL && new_byte && lnk.is_data && s_r.sel && s_r.set == SET_DATA && top == SEL_EMPH
            |=> ##1 emphasis_out == $past(val[EMPH_HI:EMPH_LO], 2) && playback_silence_out == $past(val[MUTE_BIT], 2);
    endproperty
    a_emph_byte: assert property (p_emph_byte) else $error("emphasis byte not applied");

    property p_power_byte;
        s_r.mode == MODE_SERIAL && new_byte && lnk.is_data && s_r.sel && s_r.set == SET_DATA && top == SEL_POWER
            |=> ##1 adc_power_enable_out == $past(val[PWR_ADC], 2) && dac_power_enable_out == $past(val[PWR_DAC], 2);
    endproperty
    a_power_byte: assert property (p_power_byte) else $error("power byte not applied");

    c_select: cover property (new_byte && !lnk.is_data ##1 port_selected_out);
    c_volume: cover property (new_byte && lnk.is_data && s_r.sel && top == SEL_ATTEN);
    c_static: cover property (s_r.mode == MODE_STATIC && p.play == LVL_MID);
endmodule // codec_config
`default_nettype wire

// >>> verification/host_port_model.sv
// host_port_model: host end of the write-only three-wire control port
// assumes: port clock idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module host_port_model #(
    parameter realtime HALF_NS = 7.5
) (
    output var logic port_clock_line_out, // host only drives; nothing is read back
    output var logic port_phase_line_out,
    output var logic port_data_line_out
);
    initial begin
        port_clock_line_out = 1'b0;
        port_phase_line_out = 1'b0;
        port_data_line_out  = 1'b0;
    end

    // phase low with n = 8 makes an address byte
    task automatic send_bits(input logic ph, input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            port_phase_line_out = ph;
            port_data_line_out  = v[i]; // lsb goes out first
            #(HALF_NS) port_clock_line_out = 1'b1;
            #(HALF_NS) port_clock_line_out = 1'b0;
        end
        port_data_line_out = ~port_data_line_out;
        #300; // gap keeps byte rate low enough for the crossing
    endtask
endmodule // host_port_model
`default_nettype wire

// >>> verification/codec_config_tb.sv
// codec_config_tb: self-checking bench for the codec configuration block
// assumes: host_port_model plays the host; bench writes each setting just before checking it
`timescale 1ns/1ps
`default_nettype none
module codec_config_tb;
    import codec_cfg_pkg::*;
    localparam logic [5:0] DEV = 6'h2a; // arbitrary device address
    logic ref_clk_in = 1'b0, rst_in = 1'b1;
    logic port_clock_line_in, port_phase_line_in, port_data_line_in;
    logic mode_select_pin_a_in = 1'b0, mode_select_pin_b_in = 1'b0;
    logic format_pin_a_in = 1'b0, format_pin_b_in = 1'b0, clock_ratio_pin_in = 1'b0;
    logic [1:0] playback_three_level_pin_in = 2'h0, adc_three_level_pin_in = 2'h0;
    mode_e control_mode_out;
    logic port_selected_out, offset_removal_enable_out, full_attenuation_out, playback_silence_out;
    logic adc_power_enable_out, dac_power_enable_out, adc_gain_6db_out;
    logic [1:0] clock_ratio_out, emphasis_out;
    logic [2:0] serial_format_out;
    logic [5:0] attenuation_code_out, attenuation_db_out;
    int errors = 0, samples_checked = 0, cycles = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    host_port_model host (.port_clock_line_out(port_clock_line_in), .port_phase_line_out(port_phase_line_in),
                          .port_data_line_out(port_data_line_in));
    codec_config #(.DEVICE_ADDRESS(DEV)) dut (.ref_clk_in, .rst_in, .port_clock_line_in, .port_phase_line_in,
        .port_data_line_in, .mode_select_pin_a_in, .mode_select_pin_b_in, .format_pin_a_in, .format_pin_b_in,
        .clock_ratio_pin_in, .playback_three_level_pin_in, .adc_three_level_pin_in, .control_mode_out,
        .port_selected_out, .clock_ratio_out, .serial_format_out, .offset_removal_enable_out,
        .attenuation_code_out, .attenuation_db_out, .full_attenuation_out, .emphasis_out,
        .playback_silence_out, .adc_power_enable_out, .dac_power_enable_out, .adc_gain_6db_out);

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle();
        repeat (8) @(posedge ref_clk_in);
    endtask
    task automatic addr(input logic [5:0] id, input logic [1:0] set);
        host.send_bits(1'b0, {id, set}, 8);
        settle();
    endtask
    task automatic dat(input logic [7:0] v);
        host.send_bits(1'b1, v, 8);
        settle();
    endtask

    task automatic t_select();
        addr(DEV, SET_DATA);
        check({7'h0, port_selected_out}, 8'h01, "own address");
        addr(DEV ^ 6'h01, SET_DATA);
        check({7'h0, port_selected_out}, 8'h00, "foreign address");
        addr(DEV, SET_DATA);
        dat(8'h05);
        check({2'h0, attenuation_code_out}, 8'h05, "volume code");
        check({2'h0, attenuation_db_out}, 8'h04, "volume db");
        dat(8'h01);
        check({2'h0, attenuation_db_out}, 8'h00, "unity db");
        dat(8'h3f);
        check({7'h0, full_attenuation_out}, 8'h01, "full atten");
        dat(8'h02);
        check({2'h0, attenuation_db_out}, 8'h01, "one db");
        check({7'h0, full_attenuation_out}, 8'h00, "not full");
        $display("test select done");
    endtask

    task automatic t_data();
        for (int e = 0; e < 8; e++) begin
            dat({3'b100, e[2:1], e[0], 2'b00});
            check({6'h0, emphasis_out}, {6'h0, e[2:1]}, "emphasis");
            check({7'h0, playback_silence_out}, {7'h0, e[0]}, "mute");
        end
        for (int p = 0; p < 4; p++) begin
            dat({6'b110000, p[1:0]});
            check({6'h0, adc_power_enable_out, dac_power_enable_out}, {6'h0, p[1:0]}, "power");
        end
        dat(8'h7f);
        check({2'h0, attenuation_code_out}, 8'h02, "unused code");
        host.send_bits(1'b1, 8'h09, 7);
        settle();
        check({2'h0, attenuation_code_out}, 8'h02, "seven bits");
        addr(DEV, SET_DATA);
        dat(8'h09);
        check({2'h0, attenuation_code_out}, 8'h09, "after partial");
        $display("test data done");
    endtask

    task automatic t_status();
        addr(DEV, SET_STATUS);
        for (int f = 0; f < 8; f++) begin
            dat({2'b00, 2'(f % 3), f[2:0], f[0]});
            check({6'h0, clock_ratio_out}, 8'(f % 3), "ratio");
            check({5'h0, serial_format_out}, {5'h0, f[2:0]}, "format");
            check({7'h0, offset_removal_enable_out}, {7'h0, f[0]}, "dc filter");
        end
        dat(8'h40);
        check({5'h0, serial_format_out}, 8'h07, "status code 01");
        addr(DEV, 2'b01);
        dat(8'h10);
        check({2'h0, attenuation_code_out}, 8'h09, "unused set");
        addr(~DEV, SET_DATA);
        dat(8'h0c);
        check({2'h0, attenuation_code_out}, 8'h09, "deselected");
        $display("test status done");
    endtask

    task automatic pins(input logic [1:0] m, input logic [1:0] f, input logic r, input logic [1:0] pl, ad);
        @(posedge ref_clk_in);
        #1;
        {mode_select_pin_a_in, mode_select_pin_b_in} = m;
        {format_pin_a_in, format_pin_b_in} = f;
        clock_ratio_pin_in = r;
        playback_three_level_pin_in = pl;
        adc_three_level_pin_in = ad;
        settle();
    endtask

    task automatic t_static();
        logic [1:0] lv [4] = '{LVL_LOW, LVL_MID, LVL_HIGH, LVL_HIGH};
        logic [2:0] fm [4] = '{FMT_MSB, FMT_I2S, FMT_MSB_L20, FMT_MSB_L16};
        pins(2'b00, 2'b01, 1'b0, LVL_LOW, LVL_LOW);
        check({7'h0, adc_gain_6db_out}, 8'h01, "serial gain pin");
        pins(2'b10, 2'b01, 1'b0, LVL_LOW, LVL_LOW);
        check({6'h0, control_mode_out}, {6'h0, MODE_TEST}, "test mode");
        for (int i = 0; i < 4; i++) begin
            pins(2'b11, i[1:0], i[0], lv[i], lv[i]);
            check({6'h0, control_mode_out}, {6'h0, MODE_STATIC}, "static mode");
            check({5'h0, serial_format_out}, {5'h0, fm[i]}, "static format");
            check({6'h0, emphasis_out}, (i == 1) ? {6'h0, EMPH_44K1} : 8'h00, "pin emphasis");
            check({7'h0, playback_silence_out}, {7'h0, i > 1}, "pin mute");
            check({7'h0, adc_power_enable_out}, {7'h0, i > 0}, "pin adc power");
            if (i > 0) check({7'h0, adc_gain_6db_out}, {7'h0, i == 1}, "pin gain");
            check({6'h0, clock_ratio_out}, i[0] ? {6'h0, RATIO_384} : {6'h0, RATIO_256}, "pin ratio");
        end
        pins(2'b00, 2'b00, 1'b0, LVL_LOW, LVL_LOW);
        check({6'h0, control_mode_out}, {6'h0, MODE_SERIAL}, "serial mode");
        $display("test static done");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_in);
        host.send_bits(1'b0, 8'h00, 4);
        @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        // lets the port domain leave reset; the stray bits are dropped at the phase change
        host.send_bits(1'b1, 8'hff, 3);
        t_select();
        t_data();
        t_status();
        t_static();
        final_report();
    end
endmodule // codec_config_tb
`default_nettype wire
